// ### hdl/lis_pkg.sv
// Constants, types and register map of the line interrupt, status and termination block.
// Assumes a byte-wide register port on the 200 MHz system clock.

package lis_pkg;

    // Register byte addresses
    localparam logic [7:0] LIS_ADDR_COUNT_CTRL = 8'h31;
    localparam logic [7:0] LIS_ADDR_TERM = 8'h32;
    localparam logic [7:0] LIS_ADDR_EN_LINE = 8'h33;
    localparam logic [7:0] LIS_ADDR_EN_ERR = 8'h34;
    localparam logic [7:0] LIS_ADDR_EDGE = 8'h35;
    localparam logic [7:0] LIS_ADDR_LINE = 8'h36;
    localparam logic [7:0] LIS_ADDR_GAIN = 8'h37;
    localparam logic [7:0] LIS_ADDR_FLAG_LINE = 8'h3A;
    localparam logic [7:0] LIS_ADDR_FLAG_ERR = 8'h3B;
    localparam logic [7:0] LIS_ADDR_CNT_HI = 8'h3C;
    localparam logic [7:0] LIS_ADDR_CNT_LO = 8'h3D;

    // Field positions
    localparam int LIS_BIT_STROBE = 0;
    localparam int LIS_BIT_MODE = 1;
    localparam int LIS_BIT_ABSENT = 0;
    localparam int LIS_BIT_DF = 2;
    localparam int LIS_BIT_ABSENT_EN = 2;
    localparam int LIS_BIT_DF_EN = 4;
    localparam int LIS_TX_TERM_LSB = 3;

    // Reset values
    localparam logic [7:0] LIS_RST_COUNT_CTRL = 8'h00;
    localparam logic [5:0] LIS_RST_TERM = 6'h07;
    localparam logic [7:0] LIS_RST_ZERO = 8'h00;

    // Error flag layout mask (bits 6..4 and 2..0)
    localparam logic [7:0] LIS_ERR_MASK = 8'h77;
    localparam logic [4:0] LIS_GAIN_MAX = 5'h15;

    // Automatic report period
    localparam int unsigned LIS_CLK_HZ = 200_000_000;
    localparam int unsigned LIS_REPORT_PERIOD_S = 1;
    localparam int unsigned LIS_REPORT_CYCLES = LIS_CLK_HZ * LIS_REPORT_PERIOD_S;

    typedef enum logic [2:0] {
        LIS_IMP_75,
        LIS_IMP_120,
        LIS_IMP_100,
        LIS_IMP_110,
        LIS_IMP_NONE
    } lis_imp_e;

    // Line conditions from the analog front end, same clock
    typedef struct packed {
        logic driver_fault;
        logic signal_absent;
    } lis_line_s;

    // One-cycle event pulses from the error detectors
    typedef struct packed {
        logic template_overrange;
        logic tx_jitter_fifo;
        logic rx_jitter_fifo;
        logic excess_zero_event;
        logic bipolar_violation;
        logic counter_overflow;
    } lis_evt_s;

endpackage : lis_pkg

// ### hdl/lis_top.sv
// Register side of the line interface: counter snapshot, termination select,
// line status, edge-selected line flags, error event flags and the active-low interrupt pin.
// Assumes line conditions, event pulses and the counter are on i_clk_sys.
`timescale 1ns/1ps
`default_nettype none

module lis_top #(
    parameter int unsigned REPORT_CYCLES = lis_pkg::LIS_REPORT_CYCLES
) (
    input wire logic i_clk_sys,
    input wire logic i_rst_b,
    input wire logic [7:0] i_addr,
    input wire logic [7:0] i_wr_data,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [7:0] o_rd_data,
    input wire lis_pkg::lis_line_s i_line,
    input wire lis_pkg::lis_evt_s i_evt,
    input wire logic [15:0] i_excess_zero_count,
    input wire logic [4:0] i_rx_gain_level,
    output lis_pkg::lis_imp_e o_tx_impedance,
    output lis_pkg::lis_imp_e o_rx_impedance,
    output logic o_irq_b
);
    import lis_pkg::*;

    // Code to impedance, shared by both directions
    function automatic lis_imp_e term_decode(input logic [2:0] code);
        lis_imp_e imp;
        imp = LIS_IMP_NONE;
        case (code)
            3'h0: imp = LIS_IMP_75;
            3'h1: imp = LIS_IMP_120;
            3'h2: imp = LIS_IMP_100;
            3'h3: imp = LIS_IMP_110;
            default: imp = LIS_IMP_NONE;
        endcase
        return imp;
    endfunction : term_decode

    // Software-written registers
    logic snapshot_strobe;
    logic report_mode_sel;
    logic [5:0] termination_select;
    logic [7:0] irq_enable_line;
    logic [7:0] irq_enable_errors;
    logic [7:0] irq_edge_select;
    // Hardware state
    logic strobe_prev;
    lis_line_s line_prev;
    logic signal_absent_flag;
    logic driver_fault_flag;
    logic [7:0] err_flags;
    logic [15:0] count_snapshot;
    logic [4:0] rx_gain_level;
    logic [31:0] sec_count;
    logic sec_tick;

    // Address decode
    wire wr_ctrl = i_wr && (i_addr == LIS_ADDR_COUNT_CTRL);
    wire wr_term = i_wr && (i_addr == LIS_ADDR_TERM);
    wire wr_en_line = i_wr && (i_addr == LIS_ADDR_EN_LINE);
    wire wr_en_err = i_wr && (i_addr == LIS_ADDR_EN_ERR);
    wire wr_edge = i_wr && (i_addr == LIS_ADDR_EDGE);
    wire wr_flag_line = i_wr && (i_addr == LIS_ADDR_FLAG_LINE);
    wire wr_flag_err = i_wr && (i_addr == LIS_ADDR_FLAG_ERR);

    // Enable and edge-select fields
    wire signal_absent_irq_en = irq_enable_line[LIS_BIT_ABSENT_EN];
    wire driver_fault_irq_en = irq_enable_line[LIS_BIT_DF_EN];
    wire signal_absent_edge_sel = irq_edge_select[LIS_BIT_ABSENT];
    wire driver_fault_edge_sel = irq_edge_select[LIS_BIT_DF];

    // Strobe edge against previous-cycle value, only in manual mode
    wire strobe_rise = snapshot_strobe && !strobe_prev;
    wire manual_copy = strobe_rise && !report_mode_sel;
    wire auto_copy = sec_tick && report_mode_sel;
    wire do_copy = manual_copy || auto_copy;

    // Line-status edges; both-edge mode also catches the fall
    wire absent_rise = i_line.signal_absent && !line_prev.signal_absent;
    wire absent_fall = !i_line.signal_absent && line_prev.signal_absent;
    wire df_rise = i_line.driver_fault && !line_prev.driver_fault;
    wire df_fall = !i_line.driver_fault && line_prev.driver_fault;
    wire absent_set = absent_rise || (signal_absent_edge_sel && absent_fall);
    wire df_set = df_rise || (driver_fault_edge_sel && df_fall);

    // Error events laid out as in the status register
    wire [7:0] err_set = {1'b0, i_evt.template_overrange, i_evt.tx_jitter_fifo,
                          i_evt.rx_jitter_fifo, 1'b0, i_evt.excess_zero_event,
                          i_evt.bipolar_violation, i_evt.counter_overflow};
    wire [7:0] err_clr = wr_flag_err ? i_wr_data : 8'h00;
    wire [7:0] next_err_flags = ((err_flags & ~err_clr) | err_set) & LIS_ERR_MASK;

    // Set beats a simultaneous write-one clear
    wire next_absent_flag = absent_set ||
        (signal_absent_flag && !(wr_flag_line && i_wr_data[LIS_BIT_ABSENT]));
    wire next_df_flag = df_set ||
        (driver_fault_flag && !(wr_flag_line && i_wr_data[LIS_BIT_DF]));

    // Interrupt request: any enabled flag; disabled flags still stick
    wire line_pending = (signal_absent_flag && signal_absent_irq_en) ||
                        (driver_fault_flag && driver_fault_irq_en);
    wire err_pending = |(err_flags & irq_enable_errors & LIS_ERR_MASK);
    wire irq_pending = line_pending || err_pending;

    // Gain clamps at the top band
    wire [4:0] next_gain = (i_rx_gain_level > LIS_GAIN_MAX) ? LIS_GAIN_MAX
                                                           : i_rx_gain_level;

    // Read-back views
    wire [7:0] ctrl_view = {6'h00, report_mode_sel, snapshot_strobe};
    wire [7:0] line_view = {5'h00, i_line.driver_fault, 1'b0, i_line.signal_absent};
    wire [7:0] flag_line_view = {5'h00, driver_fault_flag, 1'b0, signal_absent_flag};
    logic [7:0] next_rd_data;

    // Read multiplexer; unmapped addresses answer zero
    always_comb
    begin
        case (i_addr)
            LIS_ADDR_COUNT_CTRL: next_rd_data = ctrl_view;
            LIS_ADDR_TERM: next_rd_data = {2'h0, termination_select};
            LIS_ADDR_EN_LINE: next_rd_data = irq_enable_line;
            LIS_ADDR_EN_ERR: next_rd_data = irq_enable_errors;
            LIS_ADDR_EDGE: next_rd_data = irq_edge_select;
            LIS_ADDR_LINE: next_rd_data = line_view;
            LIS_ADDR_GAIN: next_rd_data = {3'h0, rx_gain_level};
            LIS_ADDR_FLAG_LINE: next_rd_data = flag_line_view;
            LIS_ADDR_FLAG_ERR: next_rd_data = err_flags;
            LIS_ADDR_CNT_HI: next_rd_data = count_snapshot[15:8];
            LIS_ADDR_CNT_LO: next_rd_data = count_snapshot[7:0];
            default: next_rd_data = 8'h00;
        endcase
    end

    // Read data stands only in the cycle after the strobe
    always_ff @(posedge i_clk_sys or negedge i_rst_b)
    begin
        if (!i_rst_b)
            o_rd_data <= 8'h00;
        else
            o_rd_data <= i_rd ? next_rd_data : 8'h00;
    end

    // Control register writes
    always_ff @(posedge i_clk_sys or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            snapshot_strobe <= LIS_RST_COUNT_CTRL[LIS_BIT_STROBE];
            report_mode_sel <= LIS_RST_COUNT_CTRL[LIS_BIT_MODE];
            termination_select <= LIS_RST_TERM;
            irq_enable_line <= LIS_RST_ZERO;
            irq_enable_errors <= LIS_RST_ZERO;
            irq_edge_select <= LIS_RST_ZERO;
        end
        else
        begin
            if (wr_ctrl)
            begin
                snapshot_strobe <= i_wr_data[LIS_BIT_STROBE];
                report_mode_sel <= i_wr_data[LIS_BIT_MODE];
            end
            if (wr_term)
                termination_select <= i_wr_data[5:0];
            if (wr_en_line)
                irq_enable_line <= i_wr_data & 8'h14; // Only the two defined bits
            if (wr_en_err)
                irq_enable_errors <= i_wr_data & LIS_ERR_MASK;
            if (wr_edge)
                irq_edge_select <= i_wr_data & 8'h05;
        end
    end

    // Previous-cycle copies for edge detection
    always_ff @(posedge i_clk_sys or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            strobe_prev <= 1'b0;
            line_prev <= '0;
        end
        else
        begin
            strobe_prev <= snapshot_strobe;
            line_prev <= i_line;
        end
    end

    // Sticky event flags
    always_ff @(posedge i_clk_sys or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            signal_absent_flag <= 1'b0;
            driver_fault_flag <= 1'b0;
            err_flags <= LIS_RST_ZERO;
        end
        else
        begin
            signal_absent_flag <= next_absent_flag;
            driver_fault_flag <= next_df_flag;
            err_flags <= next_err_flags;
        end
    end

    // One-second divider; a free-running tick keeps auto reports evenly spaced
    always_ff @(posedge i_clk_sys or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            sec_count <= 32'h0;
            sec_tick <= 1'b0;
        end
        else if (sec_count == 32'(REPORT_CYCLES - 1))
        begin
            sec_count <= 32'h0;
            sec_tick <= 1'b1;
        end
        else
        begin
            sec_count <= sec_count + 32'h1;
            sec_tick <= 1'b0;
        end
    end

    // Counter snapshot and gain sample
    always_ff @(posedge i_clk_sys or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            count_snapshot <= 16'h0000;
            rx_gain_level <= 5'h00;
        end
        else
        begin
            if (do_copy)
                count_snapshot <= i_excess_zero_count;
            rx_gain_level <= next_gain;
        end
    end

    // Termination outputs and interrupt pin, all registered
    always_ff @(posedge i_clk_sys or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            o_tx_impedance <= LIS_IMP_75;
            o_rx_impedance <= LIS_IMP_NONE;
            o_irq_b <= 1'b1;
        end
        else
        begin
            o_tx_impedance <= term_decode(termination_select[LIS_TX_TERM_LSB +: 3]);
            o_rx_impedance <= term_decode(termination_select[2:0]);
            o_irq_b <= !irq_pending;
        end
    end

    // Checks
    default clocking cb @(posedge i_clk_sys);
    endclocking
    default disable iff (!i_rst_b);

    a_manual_snapshot_copy:
    assert property (manual_copy |=> count_snapshot == $past(i_excess_zero_count))
    else $error("manual snapshot did not copy the counter");

    a_auto_ignores_strobe:
    assert property (report_mode_sel && strobe_rise && !sec_tick |=> $stable(count_snapshot))
    else $error("strobe acted in automatic mode");

    a_auto_second_copy:
    assert property (sec_tick && report_mode_sel |=> count_snapshot == $past(i_excess_zero_count))
    else $error("automatic report did not copy the counter");

    a_tx_term_map:
    assert property (termination_select[5:3] == 3'h3 |=> o_tx_impedance == LIS_IMP_110)
    else $error("transmit code 011 did not give 110 ohm");

    a_rx_term_map:
    assert property (termination_select[2:0] == 3'h1 |=> o_rx_impedance == LIS_IMP_120)
    else $error("receive code 001 did not give 120 ohm");

    a_rx_bypass_sel:
    assert property (termination_select[2] |=> o_rx_impedance == LIS_IMP_NONE)
    else $error("receive code 1xx did not bypass matching");

    a_absent_rise_sets:
    assert property ($rose(i_line.signal_absent) |=> signal_absent_flag)
    else $error("signal-absent rise did not set its flag");

    a_absent_fall_quiet:
    assert property (!signal_absent_edge_sel && !signal_absent_flag && !absent_rise
                     |=> !signal_absent_flag)
    else $error("signal-absent flag set without a rise");

    a_df_both_edges:
    assert property (driver_fault_edge_sel && $changed(i_line.driver_fault)
                     |=> driver_fault_flag)
    else $error("driver-fault change missed in both-edge mode");

    a_flag_sticky_hold:
    assert property (driver_fault_flag && !wr_flag_line |=> driver_fault_flag)
    else $error("driver-fault flag dropped without a clear");

    a_masked_no_irq:
    assert property (!irq_pending |=> o_irq_b)
    else $error("interrupt asserted with no enabled flag");

    a_enabled_irq_low:
    assert property (signal_absent_flag && signal_absent_irq_en |=> !o_irq_b)
    else $error("enabled signal-absent flag did not pull interrupt");

    a_err_gate_irq:
    assert property (err_flags[1] && irq_enable_errors[1] ##1 1'b1 |-> !o_irq_b)
    else $error("enabled violation flag did not pull interrupt");

    a_gain_saturate:
    assert property (i_rx_gain_level >= 5'h15 |=> rx_gain_level == LIS_GAIN_MAX)
    else $error("gain indication did not saturate");

    a_no_rise_no_copy:
    assert property (!report_mode_sel && !strobe_rise |=> $stable(count_snapshot))
    else $error("counter copied without a strobe rise");

    a_tx_code_zero:
    assert property (termination_select[5:3] == 3'h0 |=> o_tx_impedance == LIS_IMP_75)
    else $error("transmit code 000 did not give 75 ohm");

    a_tx_reserved_code:
    assert property (termination_select[5] |=> o_tx_impedance == LIS_IMP_NONE)
    else $error("reserved transmit code selected a matching");

    a_rx_code_two:
    assert property (termination_select[2:0] == 3'h2 |=> o_rx_impedance == LIS_IMP_100)
    else $error("receive code 010 did not give 100 ohm");

    a_err_events_set:
    assert property (err_set != 8'h00 |=> (err_flags & $past(err_set)) == $past(err_set))
    else $error("error event did not set its flag");

    a_absent_set_wins:
    assert property (absent_set |=> signal_absent_flag)
    else $error("signal-absent set lost to a clear");

    a_df_clear_write:
    assert property (wr_flag_line && i_wr_data[LIS_BIT_DF] && !df_set |=> !driver_fault_flag)
    else $error("driver-fault flag ignored its write-one clear");

    a_err_flag_clear:
    assert property (wr_flag_err && err_set == 8'h00
                     |=> (err_flags & $past(i_wr_data)) == 8'h00)
    else $error("error flag ignored its write-one clear");

    a_irq_needs_flag:
    assert property (!o_irq_b |-> $past(irq_pending))
    else $error("interrupt low without an enabled flag");

    a_df_status_view:
    assert property (i_rd && i_addr == LIS_ADDR_LINE
                     |=> o_rd_data[LIS_BIT_DF] == $past(i_line.driver_fault))
    else $error("line status did not show driver failure");

    a_absent_status_view:
    assert property (i_rd && i_addr == LIS_ADDR_LINE
                     |=> o_rd_data[LIS_BIT_ABSENT] == $past(i_line.signal_absent))
    else $error("line status did not show signal absence");

    a_gain_passes_low:
    assert property (i_rx_gain_level < LIS_GAIN_MAX
                     |=> rx_gain_level == $past(i_rx_gain_level))
    else $error("gain indication below the top band changed");

endmodule : lis_top

`default_nettype wire

// ### testbench/lis_host_model.sv
// Host processor model: drives byte writes and reads on the register port.
// Assumes read data stands only in the cycle after the read strobe.
`timescale 1ns/1ps
`default_nettype none

module lis_host_model (
    input wire logic i_clk_sys,
    input wire logic [7:0] i_rd_data,
    output logic [7:0] o_addr,
    output logic [7:0] o_wr_data,
    output logic o_wr,
    output logic o_rd
);
    import lis_pkg::*;

    // Idle bus from time zero so no strobe floats
    initial
    begin
        o_addr = 8'h00;
        o_wr_data = 8'h00;
        o_wr = 1'b0;
        o_rd = 1'b0;
    end

    // One-cycle write; address and data hold through the taking edge
    task automatic wr_reg(input logic [7:0] addr, input logic [7:0] data);
        @(posedge i_clk_sys);
        o_wr <= 1'b1;
        o_addr <= addr;
        o_wr_data <= data;
        @(posedge i_clk_sys);
        o_wr <= 1'b0;
    endtask : wr_reg

    // Answer is taken just after the edge that closes the strobe cycle
    task automatic rd_reg(input logic [7:0] addr, output logic [7:0] data);
        @(posedge i_clk_sys);
        o_rd <= 1'b1;
        o_addr <= addr;
        @(posedge i_clk_sys);
        o_rd <= 1'b0;
        #1;
        data = i_rd_data;
    endtask : rd_reg

    // Only a fresh rise copies, so the strobe is cleared before each request
    task automatic snapshot();
        wr_reg(LIS_ADDR_COUNT_CTRL, 8'h00);
        wr_reg(LIS_ADDR_COUNT_CTRL, 8'h01);
    endtask : snapshot
endmodule : lis_host_model
`default_nettype wire

// ### testbench/tb_lis_top.sv
// Self-checking bench for the line interrupt, status and termination block.
// Assumes the host model drives the register port; the bench drives line inputs.
`timescale 1ns/1ps
`default_nettype none

module tb_lis_top;
    import lis_pkg::*;

    logic i_clk_sys = 1'b0;
    logic i_rst_b = 1'b0;
    logic [7:0] i_addr;
    logic [7:0] i_wr_data;
    logic i_wr;
    logic i_rd;
    logic [7:0] o_rd_data;
    lis_line_s i_line = '0;
    lis_evt_s i_evt = '0;
    logic [15:0] i_excess_zero_count = 16'h0000;
    logic [4:0] i_rx_gain_level = 5'h00;
    lis_imp_e o_tx_impedance;
    lis_imp_e o_rx_impedance;
    logic o_irq_b;
    int failures = 0;
    int n_checks = 0;
    const lis_imp_e imp_map [4] = '{LIS_IMP_75, LIS_IMP_120, LIS_IMP_100, LIS_IMP_110};

    always #2.5 i_clk_sys = ~i_clk_sys;

    // Short report period keeps the automatic copy within reach of the run
    lis_top #(.REPORT_CYCLES(50)) lis_top_inst (.i_clk_sys(i_clk_sys), .i_rst_b(i_rst_b),
        .i_addr(i_addr), .i_wr_data(i_wr_data), .i_wr(i_wr), .i_rd(i_rd),
        .o_rd_data(o_rd_data), .i_line(i_line), .i_evt(i_evt),
        .i_excess_zero_count(i_excess_zero_count),
        .i_rx_gain_level(i_rx_gain_level), .o_tx_impedance(o_tx_impedance),
        .o_rx_impedance(o_rx_impedance), .o_irq_b(o_irq_b));

    lis_host_model lis_host_model_inst (.i_clk_sys(i_clk_sys), .i_rd_data(o_rd_data),
        .o_addr(i_addr), .o_wr_data(i_wr_data), .o_wr(i_wr), .o_rd(i_rd));

    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task automatic rd_chk(input string name, input logic [7:0] addr, input logic [7:0] exp);
        logic [7:0] d;
        lis_host_model_inst.rd_reg(addr, d);
        check(name, d, exp);
    endtask : rd_chk

    task automatic wr(input logic [7:0] addr, input logic [7:0] data);
        lis_host_model_inst.wr_reg(addr, data);
    endtask : wr

    // Settle past the fixed pipeline figures before looking at pins
    task automatic settle(input int n);
        repeat (n) @(posedge i_clk_sys);
        #1;
    endtask : settle

    task automatic chk_irq(input logic exp);
        check("irq_b", {7'h00, o_irq_b}, {7'h00, exp});
    endtask : chk_irq

    task automatic reset_state();
        rd_chk("term_rst", LIS_ADDR_TERM, 8'h07);
        rd_chk("en_line_rst", LIS_ADDR_EN_LINE, 8'h00);
        rd_chk("flag_err_rst", LIS_ADDR_FLAG_ERR, 8'h00);
        rd_chk("cnt_hi_rst", LIS_ADDR_CNT_HI, 8'h00);
        check("tx_rst", {5'h00, o_tx_impedance}, {5'h00, LIS_IMP_75});
        check("rx_rst", {5'h00, o_rx_impedance}, {5'h00, LIS_IMP_NONE});
        chk_irq(1'b1);
        rd_chk("unmapped", 8'h40, 8'h00);
        wr(LIS_ADDR_LINE, 8'hFF);
        rd_chk("ro_write", LIS_ADDR_LINE, 8'h00);
    endtask : reset_state

    // Every transmit and receive code, reserved ones included
    task automatic termination();
        for (int c = 0; c < 8; c++)
        begin
            wr(LIS_ADDR_TERM, 8'((c << 3) | (7 - c)));
            settle(2);
            check("tx_imp", {5'h00, o_tx_impedance},
                {5'h00, (c > 3) ? LIS_IMP_NONE : imp_map[c % 4]});
            check("rx_imp", {5'h00, o_rx_impedance},
                {5'h00, (c < 4) ? LIS_IMP_NONE : imp_map[(7 - c) % 4]});
        end
    endtask : termination

    // Signal-absent then driver-fault: rising-only, then both-edge flag setting
    task automatic line_flags();
        logic [7:0] b;
        logic [7:0] en;
        for (int i = 0; i < 2; i++)
        begin
            b = (i == 0) ? 8'h01 : 8'h04;
            en = (i == 0) ? 8'h04 : 8'h10;
            wr(LIS_ADDR_EDGE, 8'h00);
            i_line[i] <= 1'b1;
            settle(3);
            rd_chk("status_set", LIS_ADDR_LINE, b);
            rd_chk("flag_rise", LIS_ADDR_FLAG_LINE, b);
            chk_irq(1'b1);
            wr(LIS_ADDR_EN_LINE, en ^ 8'h14);
            settle(3);
            chk_irq(1'b1);
            wr(LIS_ADDR_FLAG_LINE, b);
            i_line[i] <= 1'b0;
            settle(3);
            rd_chk("flag_fall_ignored", LIS_ADDR_FLAG_LINE, 8'h00);
            rd_chk("status_clr", LIS_ADDR_LINE, 8'h00);
            wr(LIS_ADDR_EDGE, b);
            i_line[i] <= 1'b1;
            settle(3);
            wr(LIS_ADDR_FLAG_LINE, b);
            i_line[i] <= 1'b0;
            settle(3);
            rd_chk("flag_fall", LIS_ADDR_FLAG_LINE, b);
            wr(LIS_ADDR_EN_LINE, en);
            settle(2);
            chk_irq(1'b0);
            wr(LIS_ADDR_FLAG_LINE, b);
            settle(2);
            chk_irq(1'b1);
            wr(LIS_ADDR_EN_LINE, 8'h00);
        end
    endtask : line_flags

    // Each error event: sticky flag, masked, gated only by its own enable
    task automatic event_flags();
        logic [7:0] m;
        for (int j = 0; j < 6; j++)
        begin
            m = (j < 3) ? 8'(1 << j) : 8'(1 << (j + 1));
            i_evt[j] <= 1'b1;
            @(posedge i_clk_sys);
            i_evt[j] <= 1'b0;
            settle(3);
            rd_chk("err_flag", LIS_ADDR_FLAG_ERR, m);
            chk_irq(1'b1);
            wr(LIS_ADDR_EN_ERR, LIS_ERR_MASK ^ m);
            settle(2);
            chk_irq(1'b1);
            wr(LIS_ADDR_EN_ERR, m);
            settle(2);
            chk_irq(1'b0);
            wr(LIS_ADDR_FLAG_ERR, m);
            settle(2);
            chk_irq(1'b1);
            rd_chk("err_clr", LIS_ADDR_FLAG_ERR, 8'h00);
            wr(LIS_ADDR_EN_ERR, 8'h00);
            // Event held through the clearing write: the set has to win
            i_evt[j] <= 1'b1;
            wr(LIS_ADDR_FLAG_ERR, m);
            i_evt[j] <= 1'b0;
            rd_chk("set_wins", LIS_ADDR_FLAG_ERR, m);
            wr(LIS_ADDR_FLAG_ERR, m);
        end
    endtask : event_flags

    // Manual copies need a fresh rise; automatic mode copies on its own
    task automatic counter_copy();
        i_excess_zero_count <= 16'hA55A;
        lis_host_model_inst.snapshot();
        settle(2);
        rd_chk("cnt_hi", LIS_ADDR_CNT_HI, 8'hA5);
        rd_chk("cnt_lo", LIS_ADDR_CNT_LO, 8'h5A);
        i_excess_zero_count <= 16'h1234;
        wr(LIS_ADDR_COUNT_CTRL, 8'h01);
        settle(2);
        rd_chk("cnt_no_rise", LIS_ADDR_CNT_LO, 8'h5A);
        lis_host_model_inst.snapshot();
        settle(2);
        rd_chk("cnt_hi2", LIS_ADDR_CNT_HI, 8'h12);
        wr(LIS_ADDR_COUNT_CTRL, 8'h02);
        i_excess_zero_count <= 16'hBEEF;
        settle(60);
        rd_chk("auto_hi", LIS_ADDR_CNT_HI, 8'hBE);
        rd_chk("auto_lo", LIS_ADDR_CNT_LO, 8'hEF);
        rd_chk("mode_rd", LIS_ADDR_COUNT_CTRL, 8'h02);
        // A strobe rise in automatic mode leaves the copy to the tick
        wr(LIS_ADDR_COUNT_CTRL, 8'h03);
        rd_chk("auto_strobe", LIS_ADDR_COUNT_CTRL, 8'h03);
    endtask : counter_copy

    task automatic gain();
        i_rx_gain_level <= 5'h1F;
        settle(2);
        rd_chk("gain_sat", LIS_ADDR_GAIN, 8'h15);
        i_rx_gain_level <= 5'h0A;
        settle(2);
        rd_chk("gain", LIS_ADDR_GAIN, 8'h0A);
    endtask : gain

    task automatic complete_run();
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : complete_run

    // Hang guard: a run past its bound is counted and closed
    initial
    begin
        repeat (20000) @(posedge i_clk_sys);
        failures++;
        complete_run();
    end

    initial
    begin
        repeat (2) @(posedge i_clk_sys);
        i_rst_b <= 1'b1;
        reset_state();
        termination();
        line_flags();
        event_flags();
        counter_copy();
        gain();
        complete_run();
    end
endmodule : tb_lis_top
`default_nettype wire
